/* logic/seep_defs.vh */
// Constants for the serial byte memory pin control block.
`ifndef SEEP_DEFS_VH
`define SEEP_DEFS_VH
`define SEEP_CMD_STATUS_WRITE_CMD      8'h01
`define SEEP_CMD_WRITE     8'h02
`define SEEP_CMD_READ      8'h03
`define SEEP_CMD_CLEAR_WRITE_LATCH_CMD      8'h04
`define SEEP_CMD_STATUS_READ_CMD      8'h05
`define SEEP_CMD_SET_WRITE_LATCH_CMD      8'h06
`define SEEP_SR_PEN        7
`define SEEP_SR_BPHI       3
`define SEEP_SR_BPLO       2
`define SEEP_SR_WEL        1
`define SEEP_SR_WIP        0
`define SEEP_WRITE_TIME_US 5000
`define SEEP_CLK_MHZ       25
`define SEEP_WRITE_CYCLES  (`SEEP_WRITE_TIME_US * `SEEP_CLK_MHZ)
`define SEEP_PAGE_BYTES    16
`define SEEP_ARRAY_BYTES   1024
`endif

/* logic/seep_fifo.v */
// Small FIFO that buffers page write bytes until the write cycle commits them.
`timescale 1ns/1ps
`default_nettype none
module seep_fifo #(
   parameter WIDTH = 18,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             reset,
   input  wire             flush,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr;
   reg [AW:0]      rd_ptr;
   reg             out_full;
   wire            empty = (wr_ptr == rd_ptr);
   wire            full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire            pop   = !empty && (!out_full || out_ready);

   assign in_ready  = !full;
   assign out_valid = out_full;

   always @(posedge clk) begin
      if (in_valid && !full && !flush) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (reset || flush) begin
         wr_ptr   <= {(AW+1){1'b0}};
         rd_ptr   <= {(AW+1){1'b0}};
         out_full <= 1'b0;
         out_data <= {WIDTH{1'b0}};
      end else begin
         if (in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            out_data <= mem[rd_ptr[AW-1:0]];
            rd_ptr   <= rd_ptr + 1'b1;
            out_full <= 1'b1;
         end else if (out_ready) begin
            out_full <= 1'b0;
         end
      end
   end
endmodule // seep_fifo
`default_nettype wire

/* logic/seep_top.v */
// Serial byte memory with chip select, pause, write protect and timed write cycle.
`timescale 1ns/1ps
`default_nettype none
`include "seep_defs.vh"
module seep_top #(
   parameter WRITE_CYCLES = `SEEP_WRITE_CYCLES,
   parameter FIFO_DEPTH   = `SEEP_PAGE_BYTES
) (
   input  wire clk,
   input  wire reset,
   input  wire chip_select_n,
   input  wire serial_clock,
   input  wire serial_in,
   input  wire protect_n,
   input  wire pause_n,
   output reg  serial_out,
   output reg  serial_out_oe,
   output reg  busy
);
   localparam ST_CMD   = 3'd0;
   localparam ST_ADDR  = 3'd1;
   localparam ST_RDATA = 3'd2;
   localparam ST_WDATA = 3'd3;
   localparam ST_SRW   = 3'd4;
   localparam ST_SRR   = 3'd5;
   localparam ST_IGN   = 3'd6;

   localparam PH_IDLE = 2'd0;
   localparam PH_ARR  = 2'd1;
   localparam PH_STAT = 2'd2;
   localparam PH_WAIT = 2'd3;

   // Two stage synchronisers for the five serial and control input pins.
   reg [4:0] sync_a;
   reg [4:0] sync_b;
   reg       sck_d;
   reg       cs_d;
   wire      cs_n   = sync_b[0];
   wire      sck    = sync_b[1];
   wire      sdi    = sync_b[2];
   wire      prot_n = sync_b[3];
   wire      hold_n = sync_b[4];

   always @(posedge clk) begin
      if (reset) begin
         sync_a <= 5'h1d;
         sync_b <= 5'h1d;
         sck_d  <= 1'b0;
         cs_d   <= 1'b1;
      end else begin
         sync_a <= {pause_n, protect_n, serial_in, serial_clock, chip_select_n};
         sync_b <= sync_a;
         sck_d  <= sck;
         cs_d   <= cs_n;
      end
   end

   reg        paused;
   wire       active  = !cs_n && !paused;
   wire       sck_up  = active && sck && !sck_d;
   wire       sck_dn  = active && !sck && sck_d;
   wire       cs_rise = cs_n && !cs_d;

   reg        armed;
   reg [2:0]  state;
   reg [7:0]  shreg;
   reg [3:0]  bitcnt;
   reg [7:0]  cmd;
   reg [9:0]  addr;
   reg [7:0]  outsh;
   reg        bp_hi;
   reg        bp_lo;
   reg        pen;
   reg        write_latch_flag;
   reg        wel_arm;
   reg        wdi_arm;
   reg [3:0]  sr_new;
   reg        sr_ok;
   reg        out_live;
   reg [4:0]  nbytes;
   reg [1:0]  phase;
   reg [31:0] tcount;
   reg        prog_arr;

   wire [7:0] status = {pen, 3'b000, bp_hi, bp_lo, write_latch_flag, busy};
   wire [7:0] next_shreg = {shreg[6:0], sdi};

   // Pause may only enter and leave while the serial clock is low, except that deselection ends it at any clock level.
   always @(posedge clk) begin
      if (reset || cs_n) begin
         paused <= 1'b0;
      end else if (!sck) begin
         paused <= !hold_n;
      end
   end

   // Block protection: 00 none, 01 top quarter, 10 top half, 11 all.
   function is_locked;
      input [9:0] a;
      input       h;
      input       l;
      begin
         case ({h, l})
            2'b00:   is_locked = 1'b0;
            2'b01:   is_locked = (a[9:8] == 2'b11);
            2'b10:   is_locked = a[9];
            default: is_locked = 1'b1;
         endcase
      end
   endfunction

   // Page byte buffer, drained into the array during the timed cycle.
   wire [17:0] fifo_out;
   wire        fifo_vld;
   wire        fifo_in_ready;
   // Each of the first FIFO_DEPTH + 1 data bytes (memory plus output register) is pushed with its address at the edge that completes it.
   wire        fifo_push = armed && sck_up && (bitcnt == 4'd7) && (state == ST_WDATA) && fifo_in_ready;
   wire        drain = (phase == PH_ARR) && fifo_vld;
   wire        fifo_flush = (phase == PH_IDLE) && cs_rise && !(state == ST_WDATA && bitcnt == 4'd0 && nbytes != 5'd0);

   seep_fifo #(
      .WIDTH (18),
      .DEPTH (FIFO_DEPTH),
      .AW    (4)
   ) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .flush     (fifo_flush),
      .in_data   ({addr, next_shreg}),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_vld),
      .out_ready (drain)
   );

   reg [7:0] array_mem [0:`SEEP_ARRAY_BYTES-1];
   reg [7:0] rd_byte;
   always @(posedge clk) begin
      if (drain && !is_locked(fifo_out[17:8], bp_hi, bp_lo)) begin
         array_mem[fifo_out[17:8]] <= fifo_out[7:0];
      end
      rd_byte <= array_mem[addr];
   end

   // Serial command engine.
   always @(posedge clk) begin
      if (reset) begin
         armed     <= 1'b0;
         state     <= ST_CMD;
         shreg     <= 8'h00;
         bitcnt    <= 4'h0;
         cmd       <= 8'h00;
         addr      <= 10'h000;
         outsh     <= 8'h00;
         out_live  <= 1'b0;
         nbytes    <= 5'h00;
         sr_new    <= 4'h0;
         sr_ok     <= 1'b0;
         wel_arm   <= 1'b0;
         wdi_arm   <= 1'b0;
         serial_out    <= 1'b0;
         serial_out_oe <= 1'b0;
      end else begin
         if (!cs_n) begin
            armed <= 1'b1;
         end
         if (cs_n) begin
            state   <= ST_CMD;
            bitcnt  <= 4'h0;
            nbytes  <= 5'h00;
            wel_arm <= 1'b0;
            wdi_arm <= 1'b0;
            sr_ok   <= 1'b0;
            out_live <= 1'b0;
            serial_out_oe <= 1'b0;
         end else if (paused) begin
            serial_out_oe <= 1'b0;
         end else if (armed && sck_up) begin
            shreg  <= next_shreg;
            bitcnt <= (bitcnt == 4'd7) ? 4'd0 : bitcnt + 4'd1;
            if (bitcnt == 4'd7) begin
               case (state)
                  ST_CMD: begin
                     cmd     <= next_shreg;
                     wel_arm <= (next_shreg == `SEEP_CMD_SET_WRITE_LATCH_CMD);
                     wdi_arm <= (next_shreg == `SEEP_CMD_CLEAR_WRITE_LATCH_CMD);
                     if (next_shreg == `SEEP_CMD_READ && !busy) begin
                        state <= ST_ADDR;
                     end else if (next_shreg == `SEEP_CMD_WRITE && write_latch_flag && !busy) begin
                        state <= ST_ADDR;
                     end else if (next_shreg == `SEEP_CMD_STATUS_READ_CMD) begin
                        state <= ST_SRR;
                        outsh <= status;
                     end else if (next_shreg == `SEEP_CMD_STATUS_WRITE_CMD && write_latch_flag && !busy) begin
                        state <= ST_SRW;
                     end else begin
                        state <= ST_IGN;
                     end
                  end
                  ST_ADDR: begin
                     addr <= {addr[1:0], next_shreg};
                     if (nbytes == 5'd1) begin
                        state  <= (cmd == `SEEP_CMD_READ) ? ST_RDATA : ST_WDATA;
                        nbytes <= 5'd0;
                     end else begin
                        nbytes <= 5'd1;
                     end
                  end
                  ST_WDATA: begin
                     addr   <= {addr[9:4], addr[3:0] + 4'd1};
                     nbytes <= (nbytes == 5'd16) ? 5'd16 : nbytes + 5'd1;
                  end
                  ST_SRW: begin
                     sr_new <= {next_shreg[7], next_shreg[3:2], 1'b0};
                     sr_ok  <= prot_n || !pen;
                     state  <= ST_IGN;
                  end
                  default: begin
                  end
               endcase
            end else if (state == ST_SRW && !prot_n && pen) begin
               sr_ok <= 1'b0;
            end
         end else if (sck_dn) begin
            if (state == ST_RDATA || state == ST_SRR) begin
               serial_out_oe <= 1'b1;
               out_live      <= 1'b1;
               serial_out    <= (state == ST_RDATA && bitcnt == 4'd0) ? rd_byte[7] : outsh[7];
               outsh <= (state == ST_RDATA && bitcnt == 4'd0) ? {rd_byte[6:0], 1'b0} : {outsh[6:0], 1'b0};
               if (bitcnt == 4'd7 && state == ST_RDATA) begin
                  addr <= addr + 10'd1;
               end
               if (bitcnt == 4'd0 && state == ST_SRR) begin
                  serial_out <= status[7];
                  outsh      <= {status[6:0], 1'b0};
               end
            end
         end
         // The output comes back after a pause if it was driving before it.
         if (!cs_n && !paused && out_live) begin
            serial_out_oe <= 1'b1;
         end
      end
   end

   // Timed write cycle and status bit updates.
   always @(posedge clk) begin
      if (reset) begin
         phase    <= PH_IDLE;
         tcount   <= 32'd0;
         busy     <= 1'b0;
         write_latch_flag      <= 1'b0;
         pen      <= 1'b0;
         bp_hi    <= 1'b0;
         bp_lo    <= 1'b0;
         prog_arr <= 1'b0;
      end else begin
         case (phase)
            PH_IDLE: begin
               if (cs_rise && armed) begin
                  if (wel_arm) begin
                     write_latch_flag <= 1'b1;
                  end else if (wdi_arm) begin
                     write_latch_flag <= 1'b0;
                  end else if (state == ST_WDATA && bitcnt == 4'd0 && nbytes != 5'd0) begin
                     phase    <= PH_ARR;
                     busy     <= 1'b1;
                     prog_arr <= 1'b1;
                     tcount   <= 32'd0;
                  end else if (cmd == `SEEP_CMD_STATUS_WRITE_CMD && sr_ok && bitcnt == 4'd0) begin
                     phase  <= PH_STAT;
                     busy   <= 1'b1;
                     tcount <= 32'd0;
                  end
               end
            end
            PH_ARR, PH_STAT: begin
               if (phase == PH_STAT) begin
                  pen   <= sr_new[3];
                  bp_hi <= sr_new[2];
                  bp_lo <= sr_new[1];
               end
               // The timer runs in every busy cycle so the cycle lasts exactly WRITE_CYCLES clocks.
               tcount <= tcount + 32'd1;
               phase  <= PH_WAIT;
            end
            default: begin
               // Runs regardless of chip select or protect pin.
               if (tcount >= WRITE_CYCLES - 1 && !fifo_vld) begin
                  phase    <= PH_IDLE;
                  busy     <= 1'b0;
                  write_latch_flag      <= 1'b0;
                  prog_arr <= 1'b0;
               end else begin
                  tcount <= tcount + 32'd1;
               end
            end
         endcase
         if (phase == PH_WAIT && prog_arr && fifo_vld) begin
            phase <= PH_ARR;
         end
      end
   end
endmodule // seep_top
`default_nettype wire

/* verification/seep_master.sv */
// Bus master model that drives the serial pins of the memory.
`timescale 1ns/1ps
`default_nettype none
module seep_master (
   input  wire logic clk,
   input  wire logic serial_out,
   input  wire logic serial_out_oe,
   output var  logic chip_select_n,
   output var  logic serial_clock,
   output var  logic serial_in
);
   logic line = 1'b0;
   initial begin
      chip_select_n = 1'b1;
      serial_clock  = 1'b0;
      serial_in     = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // A released data line shows the inverse of its last level, never a held value.
   task automatic sel(input logic on);
      @(posedge clk);
      chip_select_n <= ~on;
      if (!on)
         serial_in <= ~serial_in;
      tick(8);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         serial_in <= tx[i];
         tick(4);
         serial_clock <= 1'b1;
         tick(2);
         line = serial_out_oe ? serial_out : ~line;
         rx[i] = line;
         tick(2);
         serial_clock <= 1'b0;
      end
   endtask
endmodule // seep_master
`default_nettype wire

/* verification/seep_top_sva.sv */
// Concurrent checks on the pins of the serial byte memory.
`timescale 1ns/1ps
`default_nettype none
module seep_top_sva #(
   parameter int WRITE_CYCLES = 125000,
   parameter int FIFO_DEPTH   = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic protect_n,
   input wire logic pause_n,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic busy
);
   logic [31:0] busy_len;
   logic [3:0]  fall_age;
   logic        sck_prev;
   always @(posedge clk) begin
      if (reset) begin
         busy_len <= 32'h0;
         fall_age <= 4'hf;
         sck_prev <= 1'b0;
      end else begin
         busy_len <= busy ? busy_len + 32'h1 : 32'h0;
         fall_age <= (sck_prev && !serial_clock) ? 4'h0 : ((fall_age == 4'hf) ? fall_age : fall_age + 4'h1);
         sck_prev <= serial_clock;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_deselected; chip_select_n [*6]; endsequence
   sequence s_paused; (!pause_n && !serial_clock) [*5]; endsequence
   property p_oe_idle; s_deselected |-> !serial_out_oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("output enabled while deselected");
   property p_oe_release; $rose(chip_select_n) |-> ##[1:5] !serial_out_oe; endproperty
   a_oe_release: assert property (p_oe_release) else $error("output not released on deselect");
   property p_oe_pause; s_paused |-> !serial_out_oe; endproperty
   a_oe_pause: assert property (p_oe_pause) else $error("output enabled while paused");
   property p_oe_start; $rose(serial_out_oe) |-> !chip_select_n && pause_n; endproperty
   a_oe_start: assert property (p_oe_start) else $error("output enabled without selection");
   property p_out_edge; serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> fall_age <= 4'h4; endproperty
   a_out_edge: assert property (p_out_edge) else $error("output changed away from clock fall");
   property p_busy_launch; $rose(busy) |-> $past(chip_select_n) && $past(chip_select_n, 2); endproperty
   a_busy_launch: assert property (p_busy_launch) else $error("write cycle began while selected");
   property p_busy_max; busy |-> busy_len < WRITE_CYCLES; endproperty
   a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
   property p_busy_full; $fell(busy) |-> busy_len == WRITE_CYCLES; endproperty
   a_busy_full: assert property (p_busy_full) else $error("write cycle cut short");
endmodule // seep_top_sva
bind seep_top seep_top_sva #(.WRITE_CYCLES(WRITE_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (
   .clk(clk), .reset(reset), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
   .serial_in(serial_in), .protect_n(protect_n), .pause_n(pause_n), .serial_out(serial_out),
   .serial_out_oe(serial_out_oe), .busy(busy));
`default_nettype wire

/* verification/tb_seep_top.sv */
// Self-checking bench for the serial byte memory pin control block.
`timescale 1ns/1ps
`default_nettype none
`include "seep_defs.vh"
module tb_seep_top;
   localparam int WC = 400;
   logic       clk, reset, protect_n, pause_n;
   wire        cs_n, sck, si, so, so_oe, busy;
   int         mismatches, checks_done, cycles;
   logic [7:0] rd;
   logic [7:0] img [0:1023];
   logic [9:0] tbl [0:2];
   seep_top #(.WRITE_CYCLES(WC)) dut (.clk(clk), .reset(reset), .chip_select_n(cs_n),
      .serial_clock(sck), .serial_in(si), .protect_n(protect_n), .pause_n(pause_n), .serial_out(so),
      .serial_out_oe(so_oe), .busy(busy));
   seep_master m (.clk(clk), .serial_out(so), .serial_out_oe(so_oe), .chip_select_n(cs_n),
      .serial_clock(sck), .serial_in(si));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic run(input logic [7:0] op, input logic [9:0] a, input int n, input logic [7:0] d, input logic ok);
      logic [9:0] p;
      m.sel(1'b1);
      m.xfer(op, rd);
      if (op == `SEEP_CMD_WRITE || op == `SEEP_CMD_READ) begin
         m.xfer({6'h00, a[9:8]}, rd);
         m.xfer(a[7:0], rd);
      end
      for (int i = 0; i < n; i++) begin
         p = (op == `SEEP_CMD_READ) ? a + 10'(i) : {a[9:4], a[3:0] + 4'(i)};
         m.xfer(d + 8'(i), rd);
         if (op == `SEEP_CMD_WRITE && ok)
            img[p] = d + 8'(i);
         if (op == `SEEP_CMD_READ)
            check(rd, img[p]);
      end
      m.sel(1'b0);
   endtask
   task automatic status(input logic [7:0] exp);
      run(`SEEP_CMD_STATUS_READ_CMD, 10'h000, 1, 8'h00, 1'b0);
      check(rd & 8'h8f, exp);
   endtask
   task automatic wen();
      run(`SEEP_CMD_SET_WRITE_LATCH_CMD, 10'h000, 0, 8'h00, 1'b0);
   endtask
   task automatic idle();
      m.tick(6);
      for (int i = 0; i < WC + 40 && busy !== 1'b0; i++)
         m.tick(1);
   endtask
   initial begin
      clk       = 1'b0;
      reset     = 1'b1;
      protect_n = 1'b1;
      pause_n   = 1'b1;
      tbl[0]    = 10'h3f0;
      tbl[1]    = 10'h280;
      tbl[2]    = 10'h015;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      m.tick(4);
      check({7'h00, so_oe}, 8'h00);
      status(8'h00);
      run(`SEEP_CMD_WRITE, 10'h010, 1, 8'h55, 1'b0);
      status(8'h00);
      $display("test reset and unlatched write ended");
      wen();
      status(8'h02);
      run(`SEEP_CMD_WRITE, 10'h015, 16, 8'ha0, 1'b1);
      status(8'h03);
      idle();
      status(8'h00);
      run(`SEEP_CMD_READ, 10'h010, 16, 8'h00, 1'b0);
      $display("test page write ended");
      protect_n <= 1'b0;
      wen();
      run(`SEEP_CMD_STATUS_WRITE_CMD, 10'h000, 1, 8'h80, 1'b0);
      idle();
      status(8'h80);
      wen();
      run(`SEEP_CMD_STATUS_WRITE_CMD, 10'h000, 1, 8'h8c, 1'b0);
      idle();
      run(`SEEP_CMD_CLEAR_WRITE_LATCH_CMD, 10'h000, 0, 8'h00, 1'b0);
      status(8'h80);
      protect_n <= 1'b1;
      wen();
      run(`SEEP_CMD_STATUS_WRITE_CMD, 10'h000, 1, 8'h00, 1'b0);
      idle();
      status(8'h00);
      $display("test status protection ended");
      for (int bp = 0; bp < 4; bp++) begin
         wen();
         run(`SEEP_CMD_STATUS_WRITE_CMD, 10'h000, 1, {4'h0, 2'(bp), 2'b00}, 1'b0);
         idle();
         status({4'h0, 2'(bp), 2'b00});
         for (int j = 0; j < 3; j++) begin
            wen();
            run(`SEEP_CMD_WRITE, tbl[j], 1, {4'(bp), 4'(j)}, bp <= j);
            protect_n <= 1'b0;
            idle();
            protect_n <= 1'b1;
            run(`SEEP_CMD_READ, tbl[j], 1, 8'h00, 1'b0);
         end
      end
      $display("test block protection ended");
      m.sel(1'b1);
      m.xfer(`SEEP_CMD_READ, rd);
      m.xfer(8'h00, rd);
      m.xfer(8'h15, rd);
      m.xfer(8'h00, rd);
      check(rd, img[10'h015]);
      m.tick(2);
      pause_n <= 1'b0;
      m.tick(6);
      check({7'h00, so_oe}, 8'h00);
      m.xfer(8'hff, rd);
      m.tick(2);
      pause_n <= 1'b1;
      m.tick(6);
      m.xfer(8'h00, rd);
      check(rd, img[10'h016]);
      m.sel(1'b0);
      check({7'h00, so_oe}, 8'h00);
      $display("test pause ended");
      summarize();
   end
endmodule // tb_seep_top
`default_nettype wire
